/* File: sld_pkg.sv */
// sld_pkg: constants and types shared by the status lamp driver
// assumes a 250 MHz module clock
package sld_pkg;

    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned FLASH_HALF_MS   = 500;
    // cycles per flash half period, derived from the clock rate
    localparam int unsigned FLASH_HALF_CYC  = (CLK_HZ / 1000) * FLASH_HALF_MS;
    localparam int unsigned FLASH_CNT_W     = 27;
    localparam int unsigned SYNC_STAGES     = 3;

    // lamp drive codes: bit 1 red, bit 0 green
    typedef enum logic [1:0] {
        SLD_LAMP_OFF   = 2'h0,
        SLD_LAMP_GREEN = 2'h1,
        SLD_LAMP_RED   = 2'h2
    } sld_colour_t;

    // lamp patterns
    typedef enum logic [2:0] {
        SLD_PAT_OFF     = 3'h0,
        SLD_PAT_GREEN   = 3'h1,
        SLD_PAT_GFLASH  = 3'h3,
        SLD_PAT_RFLASH  = 3'h2,
        SLD_PAT_RED     = 3'h6,
        SLD_PAT_ALT     = 3'h7
    } sld_pat_t;

    localparam logic [1:0] LAMP_RESET = 2'h0;
    localparam logic       FLASH_RESET = 1'b0;

endpackage

/* File: sld_sync.sv */
// sld_sync: three-stage synchroniser with agreement filter for one pin
// assumes input is asynchronous to clk
`timescale 1ns/1ns
module sld_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin in, filtered level out
    input  wire logic pin_in,
    output logic      level_out
);
    import sld_pkg::*;

    logic [SYNC_STAGES-1:0] stage_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
        end
    end

    // change counts once second and third stages agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_out <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            level_out <= stage_q[2];
        end
    end

endmodule

/* File: sld_flash_timer.sv */
// sld_flash_timer: shared fixed-period flash phase generator
// assumes one module clock at the package clock rate
`timescale 1ns/1ns
module sld_flash_timer (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // flash phase and half-period tick
    output logic      phase_q,
    output logic      tick_q
);
    import sld_pkg::*;

    localparam logic [FLASH_CNT_W-1:0] CNT_LAST = FLASH_CNT_W'(FLASH_HALF_CYC - 1);

    logic [FLASH_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (cnt_q == CNT_LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // equal on and off halves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= FLASH_RESET;
            tick_q  <= 1'b0;
        end else begin
            tick_q <= (cnt_q == CNT_LAST);
            if (cnt_q == CNT_LAST) begin
                phase_q <= ~phase_q;
            end
        end
    end

endmodule

/* File: sld_status_lamp_driver.sv */
// sld_status_lamp_driver: module and network health lamp drive
// assumes status inputs are asynchronous; lamps driven high-active
`timescale 1ns/1ns
module sld_status_lamp_driver (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // module status conditions
    input  wire logic self_test,
    input  wire logic fault_unrecoverable,
    input  wire logic config_missing,
    input  wire logic fault_recoverable,
    // network status conditions
    input  wire logic online,
    input  wire logic duplicate_node_check_done,
    input  wire logic conn_established,
    input  wire logic conn_timeout,
    input  wire logic link_failure,
    // module health lamp
    output logic      module_health_lamp_red,
    output logic      module_health_lamp_green,
    // network health lamp
    output logic      network_health_lamp_red,
    output logic      network_health_lamp_green
);
    import sld_pkg::*;

    // filtered condition levels
    logic       s_test;
    logic       s_unrec;
    logic       s_nocfg;
    logic       s_rec;
    logic       s_online;
    logic       s_dup_ok;
    logic       s_conn;
    logic       s_tmo;
    logic       s_link;
    logic       net_up;

    // shared flash phase
    logic       phase;

    // patterns and colour codes
    sld_pat_t   mod_pat;
    sld_pat_t   net_pat;
    logic [1:0] mod_d;
    logic [1:0] net_d;

    // separate drives of each lamp
    logic       mod_red_d;
    logic       mod_green_d;
    logic       net_red_d;
    logic       net_green_d;

    // one synchroniser per asynchronous condition pin
    sld_sync u_sync_test (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (self_test),
        .level_out (s_test)
    );

    sld_sync u_sync_unrec (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (fault_unrecoverable),
        .level_out (s_unrec)
    );

    sld_sync u_sync_nocfg (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (config_missing),
        .level_out (s_nocfg)
    );

    sld_sync u_sync_rec (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (fault_recoverable),
        .level_out (s_rec)
    );

    sld_sync u_sync_online (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (online),
        .level_out (s_online)
    );

    sld_sync u_sync_dup_ok (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (duplicate_node_check_done),
        .level_out (s_dup_ok)
    );

    sld_sync u_sync_conn (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (conn_established),
        .level_out (s_conn)
    );

    sld_sync u_sync_tmo (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (conn_timeout),
        .level_out (s_tmo)
    );

    sld_sync u_sync_link (
        .clk       (clk),
        .rst_n     (rst_n),
        .pin_in    (link_failure),
        .level_out (s_link)
    );

    // network up once online and the node check is done
    assign net_up = s_online && s_dup_ok;

    // shared flash phase for both lamps
    sld_flash_timer u_flash (
        .clk     (clk),
        .rst_n   (rst_n),
        .phase_q (phase),
        .tick_q  ()
    );

    // module lamp pattern by severity
    always_comb begin
        mod_pat = SLD_PAT_GREEN;
        if (s_test) begin
            mod_pat = SLD_PAT_ALT;
        end else if (s_unrec) begin
            mod_pat = SLD_PAT_RED;
        end else if (s_nocfg) begin
            mod_pat = SLD_PAT_GFLASH;
        end else if (s_rec) begin
            mod_pat = SLD_PAT_RFLASH;
        end else begin
            mod_pat = SLD_PAT_GREEN;
        end
    end

    // network lamp pattern by severity
    always_comb begin
        net_pat = SLD_PAT_OFF;
        if (s_test) begin
            net_pat = SLD_PAT_ALT;
        end else if (s_link) begin
            net_pat = SLD_PAT_RED;
        end else if (s_nocfg) begin
            net_pat = SLD_PAT_RFLASH;
        end else if (s_tmo) begin
            net_pat = SLD_PAT_RFLASH;
        end else if (!net_up) begin
            net_pat = SLD_PAT_OFF;
        end else if (s_conn) begin
            net_pat = SLD_PAT_GREEN;
        end else begin
            net_pat = SLD_PAT_GFLASH;
        end
    end

    // module lamp colour, all flashing on one shared phase
    always_comb begin
        mod_d = SLD_LAMP_OFF;
        case (mod_pat)
            SLD_PAT_OFF: begin
                mod_d = SLD_LAMP_OFF;
            end
            SLD_PAT_GREEN: begin
                mod_d = SLD_LAMP_GREEN;
            end
            SLD_PAT_RED: begin
                mod_d = SLD_LAMP_RED;
            end
            SLD_PAT_GFLASH: begin
                if (phase) begin
                    mod_d = SLD_LAMP_GREEN;
                end else begin
                    mod_d = SLD_LAMP_OFF;
                end
            end
            SLD_PAT_RFLASH: begin
                if (phase) begin
                    mod_d = SLD_LAMP_RED;
                end else begin
                    mod_d = SLD_LAMP_OFF;
                end
            end
            SLD_PAT_ALT: begin
                if (phase) begin
                    mod_d = SLD_LAMP_RED;
                end else begin
                    mod_d = SLD_LAMP_GREEN;
                end
            end
            default: begin
                mod_d = SLD_LAMP_OFF;
            end
        endcase
    end

    // network lamp colour, same shared phase
    always_comb begin
        net_d = SLD_LAMP_OFF;
        case (net_pat)
            SLD_PAT_OFF: begin
                net_d = SLD_LAMP_OFF;
            end
            SLD_PAT_GREEN: begin
                net_d = SLD_LAMP_GREEN;
            end
            SLD_PAT_RED: begin
                net_d = SLD_LAMP_RED;
            end
            SLD_PAT_GFLASH: begin
                if (phase) begin
                    net_d = SLD_LAMP_GREEN;
                end else begin
                    net_d = SLD_LAMP_OFF;
                end
            end
            SLD_PAT_RFLASH: begin
                if (phase) begin
                    net_d = SLD_LAMP_RED;
                end else begin
                    net_d = SLD_LAMP_OFF;
                end
            end
            SLD_PAT_ALT: begin
                if (phase) begin
                    net_d = SLD_LAMP_RED;
                end else begin
                    net_d = SLD_LAMP_GREEN;
                end
            end
            default: begin
                net_d = SLD_LAMP_OFF;
            end
        endcase
    end

    // split colour codes; one colour at a time on each lamp
    assign mod_red_d   = (mod_d == SLD_LAMP_RED);
    assign mod_green_d = (mod_d == SLD_LAMP_GREEN);
    assign net_red_d   = (net_d == SLD_LAMP_RED);
    assign net_green_d = (net_d == SLD_LAMP_GREEN);

    // module lamp red drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            module_health_lamp_red <= LAMP_RESET[1];
        end else begin
            module_health_lamp_red <= mod_red_d;
        end
    end

    // module lamp green drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            module_health_lamp_green <= LAMP_RESET[0];
        end else begin
            module_health_lamp_green <= mod_green_d;
        end
    end

    // network lamp red drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            network_health_lamp_red <= LAMP_RESET[1];
        end else begin
            network_health_lamp_red <= net_red_d;
        end
    end

    // network lamp green drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            network_health_lamp_green <= LAMP_RESET[0];
        end else begin
            network_health_lamp_green <= net_green_d;
        end
    end

endmodule

/* File: sld_lamp_chk.sv */
// sld_lamp_chk: lamp drive assertions for the status lamp driver
// assumes conditions are judged once they have been held for 8 cycles
`timescale 1ns/1ns
module sld_lamp_chk (
    input wire logic clk, rst_n, self_test, fault_unrecoverable, config_missing,
    input wire logic fault_recoverable, online, duplicate_node_check_done,
    input wire logic conn_established, conn_timeout, link_failure,
    input wire logic module_health_lamp_red, module_health_lamp_green,
    input wire logic network_health_lamp_red, network_health_lamp_green
);
    logic mr, mg, nr, ng, mq, nq, up, run_ok, hard, minor, idle, tmo;
    assign mr = module_health_lamp_red;
    assign mg = module_health_lamp_green;
    assign nr = network_health_lamp_red;
    assign ng = network_health_lamp_green;
    assign mq = !self_test && !fault_unrecoverable;
    assign nq = !self_test && !link_failure && !config_missing && !conn_timeout;
    assign up = online && duplicate_node_check_done;
    assign run_ok = mq && !config_missing && !fault_recoverable;
    assign hard = !self_test && fault_unrecoverable;
    assign minor = mq && !config_missing && fault_recoverable;
    assign idle = nq && up && !conn_established;
    assign tmo = !self_test && !link_failure && conn_timeout;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_held(c);
        c [*8];
    endsequence
    a_module_no_clash: assert property (!(mr && mg))
        else $error("module lamp red and green together");
    a_net_no_clash: assert property (!(nr && ng))
        else $error("network lamp red and green together");
    a_normal_green: assert property (s_held(run_ok) |-> mg && !mr)
        else $error("module lamp not steady green");
    a_unrec_red: assert property (s_held(hard) |-> mr && !mg)
        else $error("module lamp not steady red");
    a_standby_flash: assert property (s_held(mq && config_missing) |-> !mr && !ng)
        else $error("standby colours wrong");
    a_minor_flash: assert property (s_held(minor) |-> !mg)
        else $error("minor fault shows green");
    a_selftest_lit: assert property (s_held(self_test) |-> (mr ^ mg) && (nr ^ ng))
        else $error("self test lamps not lit one colour");
    a_net_dark: assert property (s_held(nq && !up) |-> !nr && !ng)
        else $error("network lamp lit while offline");
    a_conn_green: assert property (s_held(nq && up && conn_established) |-> ng && !nr)
        else $error("network lamp not steady green");
    a_link_red: assert property (s_held(!self_test && link_failure) |-> nr && !ng)
        else $error("network lamp not steady red");
    a_idle_no_red: assert property (s_held(idle) |-> !nr)
        else $error("network lamp red while online and idle");
    a_tmo_no_green: assert property (s_held(tmo) |-> !ng)
        else $error("network lamp green during time-out");
endmodule
bind sld_status_lamp_driver sld_lamp_chk u_chk (.clk, .rst_n, .self_test,
    .fault_unrecoverable, .config_missing, .fault_recoverable, .online,
    .duplicate_node_check_done, .conn_established, .conn_timeout, .link_failure,
    .module_health_lamp_red, .module_health_lamp_green, .network_health_lamp_red,
    .network_health_lamp_green);

/* File: sld_lamp_model.sv */
// sld_lamp_model: one red/green front-panel lamp
// assumes active-high drives; both lit gives an illegal colour code
`timescale 1ns/1ns
module sld_lamp_model (
    input wire logic          red,
    input wire logic          green,
    output sld_pkg::sld_colour_t colour
);
    import sld_pkg::*;
    assign colour = sld_colour_t'({red, green});
endmodule

/* File: sld_status_lamp_driver_tb.sv */
// sld_status_lamp_driver_tb: random condition sets against a priority model
// assumes the run ends before the first flash phase flip (phase 0 only)
`timescale 1ns/1ns
module sld_status_lamp_driver_tb;
    import sld_pkg::*;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [8:0]  cond = '0;
    logic        mr, mg, nr, ng;
    sld_colour_t m_col, n_col;
    int          miscompares = 0;
    int          n_tests = 0;
    always #2 clk = ~clk;
    sld_status_lamp_driver u_dut (.clk(clk), .rst_n(rst_n), .self_test(cond[8]),
        .fault_unrecoverable(cond[7]), .config_missing(cond[6]), .fault_recoverable(cond[5]),
        .online(cond[4]), .duplicate_node_check_done(cond[3]), .conn_established(cond[2]),
        .conn_timeout(cond[1]), .link_failure(cond[0]), .module_health_lamp_red(mr),
        .module_health_lamp_green(mg), .network_health_lamp_red(nr),
        .network_health_lamp_green(ng));
    sld_lamp_model u_mod_lamp (.red(mr), .green(mg), .colour(m_col));
    sld_lamp_model u_net_lamp (.red(nr), .green(ng), .colour(n_col));
    // expected colours in flash phase 0: flashes dark, alternation green
    function automatic sld_colour_t exp_mod(logic [8:0] c);
        if (c[8]) return SLD_LAMP_GREEN;
        if (c[7]) return SLD_LAMP_RED;
        if (c[6] || c[5]) return SLD_LAMP_OFF;
        return SLD_LAMP_GREEN;
    endfunction
    function automatic sld_colour_t exp_net(logic [8:0] c);
        if (c[8]) return SLD_LAMP_GREEN;
        if (c[0]) return SLD_LAMP_RED;
        if (c[4] && c[3] && c[2] && !c[6] && !c[1]) return SLD_LAMP_GREEN;
        return SLD_LAMP_OFF;
    endfunction
    task automatic compare_lamp(sld_colour_t got, sld_colour_t exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t lamp got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic apply(logic [8:0] c);
        cond = c;
        repeat (8) @(posedge clk);
        #1;
        compare_lamp(m_col, exp_mod(c));
        compare_lamp(n_col, exp_net(c));
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #80000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        logic [8:0] dir [9] = '{9'h000, 9'h018, 9'h01C, 9'h100, 9'h080, 9'h040, 9'h020,
                                9'h002, 9'h001};
        void'($urandom(55));
        repeat (10) @(posedge clk);
        #1;
        compare_lamp(m_col, SLD_LAMP_OFF);
        rst_n = 1;
        foreach (dir[i]) apply(dir[i]);
        $display("directed test done");
        repeat (300) apply(9'($urandom));
        $display("random test done");
        rst_n = 0;
        #8;
        compare_lamp(n_col, SLD_LAMP_OFF);
        rst_n = 1;
        apply(9'h000);
        $display("reset test done");
        report_and_stop;
    end
endmodule
